/* sesb_steer_ecc.sv */
// Storage word checker with spare-bit steering between the processor data path and storage.
// Assumes storage answers a read one cycle after the cycle in which mem_en is high.
//
// Summary of operation
// - Each four-byte word carries one seven-bit check code instead of byte parity.
// - Every fetch reads 39 bits and validates 32 data bits with the check code.
// - Fetched words leave with one generated parity bit per data byte.
// - A single-bit error is flipped with no added fetch cycles.
// - Corrections raise no machine check and are not counted.
// - Stores drop incoming parity, generate seven check bits, write 39 bits.
// - All double and many multi-bit errors are detected, never corrected.
// - Uncorrectable error during execution: check-stop plus error record, no interruption.
// - Data on internal paths stays checked by byte parity.
// - Every stored 39-bit word has one spare bit for a failing bit.
// - One replaced bit per 64K block (512K) or 128K block (1024K), eight total.
// - Dictionary loads steering registers at microcode load; accesses then use spares.
`timescale 1ns/1ps
`default_nettype none
module sesb_steer_ecc (
	input wire logic ref_clk, // Processor clock, 125 MHz
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic clk_en, // Freezes all state while low
	input wire logic iml_active, // Initial microcode load in progress
	input wire logic size_1024k, // Storage size strap, 1 = 1024K, 0 = 512K
	input wire logic dict_we, // Dictionary entry write strobe
	input wire logic [sesb_pkg::SESB_SLOT_W-1:0] dict_slot, // Storage block of the entry
	input wire logic [sesb_pkg::SESB_BIT_W-1:0] dict_bit, // Failing bit position 0..38
	input wire logic dict_en, // Entry in use
	input wire logic req_valid, // Processor access request
	input wire logic req_write, // 1 = store, 0 = fetch
	input wire logic [sesb_pkg::SESB_ADDR_W-1:0] req_addr, // Byte address
	input wire logic [sesb_pkg::SESB_DATA_W-1:0] req_data, // Store data
	input wire logic [sesb_pkg::SESB_BYTES-1:0] req_par, // Store byte parity
	input wire logic in_exec, // Access made during instruction execution
	input wire logic [sesb_pkg::SESB_MEM_W-1:0] mem_rdata, // Storage read data with spare
	output logic req_ready, // Request may be taken
	output logic fetch_valid, // Fetch answer pulse
	output logic [sesb_pkg::SESB_DATA_W-1:0] fetch_data, // Fetched data
	output logic [sesb_pkg::SESB_BYTES-1:0] fetch_par, // Generated byte parity
	output logic fetch_bad, // Fetched word uncorrectable
	output logic path_par_err, // Store data parity error pulse
	output logic check_stop, // Processor check-stop level
	output logic log_valid, // Error record pulse
	output logic [sesb_pkg::SESB_ADDR_W-1:0] log_addr, // Address of failing word
	output logic [sesb_pkg::SESB_CHK_W-1:0] log_syndrome, // Syndrome of failing word
	output logic mem_en, // Storage access strobe
	output logic mem_we, // Storage write enable
	output logic [sesb_pkg::SESB_WADDR_W-1:0] mem_addr, // Storage word address
	output logic [sesb_pkg::SESB_MEM_W-1:0] mem_wdata // Storage write data with spare
);
	import sesb_pkg::*;

	// Sequencer state and processor side results
	sesb_state_t state_q;
	logic req_ready_q;
	logic fetch_valid_q;
	logic [SESB_DATA_W-1:0] fetch_data_q;
	logic [SESB_BYTES-1:0] fetch_par_q;
	logic fetch_bad_q;
	logic path_par_err_q;

	// Check-stop level and error record
	logic check_stop_q;
	logic log_valid_q;
	logic [SESB_ADDR_W-1:0] log_addr_q;
	logic [SESB_CHK_W-1:0] log_syn_q;

	// Storage side strobes and write word
	logic mem_en_q;
	logic mem_we_q;
	logic [SESB_WADDR_W-1:0] mem_addr_q;
	logic [SESB_MEM_W-1:0] mem_wdata_q;

	// Fetch in flight and steering configuration
	logic [SESB_ADDR_W-1:0] rd_addr_q;
	logic rd_exec_q;
	logic [SESB_SLOT_W-1:0] rd_blk_q;
	logic size_1024k_q;
	logic steer_en_q [SESB_SLOTS];
	logic [SESB_BIT_W-1:0] steer_bit_q [SESB_SLOTS];

	// Request decode and store parity check
	logic req_take;
	logic [SESB_SLOT_W-1:0] req_blk;
	logic [SESB_BYTES-1:0] par_bad;

	// Store path
	logic [SESB_WORD_W-1:0] enc_word;
	logic [SESB_WORD_W-1:0] spare_pick;
	logic spare_wr;

	// Fetch path
	logic [SESB_WORD_W-1:0] rd_word;
	logic [SESB_DATA_W-1:0] dec_data;
	logic dec_uncorr;
	logic [SESB_CHK_W-1:0] dec_syn;
	logic [SESB_BYTES-1:0] gen_par;
	logic stop_hit;

	// Request acceptance and storage block of the request
	assign req_take = req_valid && req_ready_q && (state_q == SESB_IDLE);
	assign req_blk = size_1024k_q ? req_addr[SESB_BLK_LSB_1024K +: SESB_SLOT_W]
		: req_addr[SESB_BLK_LSB_512K +: SESB_SLOT_W];

	// Byte parity check on store data, parity generation on fetch data
	for (genvar i = 0; i < SESB_BYTES; i++) begin : g_par
		assign par_bad[i] = (^{req_data[i*8 +: 8], req_par[i]}) != SESB_PAR_ODD;
		assign gen_par[i] = (^dec_data[i*8 +: 8]) ^ SESB_PAR_ODD;
	end

	// Check-code generation for stores; incoming parity is not used
	sesb_encoder u_enc (
		.data_in(req_data),
		.word_out(enc_word)
	);

	// Per-bit spare steering: copy the failing bit out on store, back in on fetch
	for (genvar b = 0; b < SESB_WORD_W; b++) begin : g_steer
		assign spare_pick[b] = steer_en_q[req_blk] && (steer_bit_q[req_blk] == SESB_BIT_W'(b))
			&& enc_word[b];
		assign rd_word[b] = (steer_en_q[rd_blk_q] && (steer_bit_q[rd_blk_q] == SESB_BIT_W'(b)))
			? mem_rdata[SESB_SPARE_POS] : mem_rdata[b];
	end
	assign spare_wr = |spare_pick;

	// Check and correct the steered fetch word in the same cycle
	sesb_decoder u_dec (
		.word_in(rd_word),
		.data_out(dec_data),
		.corrected(),
		.uncorrectable(dec_uncorr),
		.syndrome(dec_syn)
	);

	// Uncorrectable word met during execution; one decode shared by three processes
	assign stop_hit = (state_q == SESB_TAKE) && dec_uncorr && rd_exec_q;

	// Storage size strap captured while microcode load runs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			size_1024k_q <= SESB_RST_LOW;
		end else if (clk_en && iml_active) begin
			size_1024k_q <= size_1024k;
		end
	end

	// Steering registers, cleared at reset, written only during microcode load
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int s = 0; s < SESB_SLOTS; s++) begin
				steer_en_q[s] <= SESB_RST_LOW;
				steer_bit_q[s] <= '0;
			end
		end else if (clk_en && iml_active && dict_we) begin
			steer_en_q[dict_slot] <= dict_en;
			steer_bit_q[dict_slot] <= dict_bit;
		end
	end

	// Access sequencer; a fetch always takes the same two cycles
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_q <= SESB_IDLE;
			req_ready_q <= SESB_RST_LOW;
		end else if (clk_en) begin
			unique case (state_q)
				SESB_IDLE: begin
					req_ready_q <= SESB_RST_HIGH;
					if (req_take && !req_write) begin
						state_q <= SESB_ISSUE;
						req_ready_q <= SESB_RST_LOW;
					end
				end
				SESB_ISSUE: begin
					state_q <= SESB_TAKE;
				end
				SESB_TAKE: begin
					if (stop_hit) begin
						state_q <= SESB_STOP;
					end else begin
						state_q <= SESB_IDLE;
						req_ready_q <= SESB_RST_HIGH;
					end
				end
				SESB_STOP: begin
					req_ready_q <= SESB_RST_LOW;
				end
			endcase
		end
	end

	// Storage side strobes, address and write word
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			mem_en_q <= SESB_RST_LOW;
			mem_we_q <= SESB_RST_LOW;
			mem_addr_q <= '0;
			mem_wdata_q <= '0;
		end else if (clk_en) begin
			mem_en_q <= SESB_RST_LOW;
			mem_we_q <= SESB_RST_LOW;
			if (req_take && (!req_write || (par_bad == '0))) begin
				mem_en_q <= SESB_RST_HIGH;
				mem_we_q <= req_write;
				mem_addr_q <= req_addr[SESB_WADDR_LSB +: SESB_WADDR_W];
			end
			if (req_take && req_write) begin
				mem_wdata_q <= {spare_wr, enc_word};
			end
		end
	end

	// Context of the fetch in flight
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rd_addr_q <= '0;
			rd_exec_q <= SESB_RST_LOW;
			rd_blk_q <= '0;
		end else if (clk_en && req_take && !req_write) begin
			rd_addr_q <= req_addr;
			rd_exec_q <= in_exec;
			rd_blk_q <= req_blk;
		end
	end

	// Fetch answer in byte-plus-parity form; correction is silent
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			fetch_valid_q <= SESB_RST_LOW;
			fetch_data_q <= '0;
			fetch_par_q <= '0;
			fetch_bad_q <= SESB_RST_LOW;
		end else if (clk_en) begin
			fetch_valid_q <= SESB_RST_LOW;
			if ((state_q == SESB_TAKE) && !stop_hit) begin
				fetch_valid_q <= SESB_RST_HIGH;
				fetch_data_q <= dec_data;
				fetch_par_q <= gen_par;
				fetch_bad_q <= dec_uncorr;
			end
		end
	end

	// Store parity error pulse; the store itself is dropped
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			path_par_err_q <= SESB_RST_LOW;
		end else if (clk_en) begin
			path_par_err_q <= req_take && req_write && (par_bad != '0);
		end
	end

	// Check-stop and error record; held until reset, no interruption raised
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			check_stop_q <= SESB_RST_LOW;
			log_valid_q <= SESB_RST_LOW;
			log_addr_q <= '0;
			log_syn_q <= '0;
		end else if (clk_en) begin
			log_valid_q <= SESB_RST_LOW;
			if (stop_hit) begin
				check_stop_q <= SESB_RST_HIGH;
				log_valid_q <= SESB_RST_HIGH;
				log_addr_q <= rd_addr_q;
				log_syn_q <= dec_syn;
			end
		end
	end

	// Processor side outputs straight from flip-flops; corrections leave no trace
	assign req_ready = req_ready_q;
	assign fetch_valid = fetch_valid_q;
	assign fetch_data = fetch_data_q;
	assign fetch_par = fetch_par_q;
	assign fetch_bad = fetch_bad_q;
	assign path_par_err = path_par_err_q;

	// Check-stop and error record outputs
	assign check_stop = check_stop_q;
	assign log_valid = log_valid_q;
	assign log_addr = log_addr_q;
	assign log_syndrome = log_syn_q;

	// Storage side outputs
	assign mem_en = mem_en_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;

endmodule // sesb_steer_ecc
`default_nettype wire

/* sesb_pkg.sv */
// Constants, state type and code helpers for the storage check and spare-bit steering block.
// Assumes a single processor clock; every file of the block imports this package.
package sesb_pkg;

	// Word layout
	localparam int SESB_DATA_W = 32;
	localparam int SESB_HAM_W = 6;
	localparam int SESB_CHK_W = 7;
	localparam int SESB_WORD_W = 39;
	localparam int SESB_MEM_W = 40;
	localparam int SESB_SPARE_POS = 39;
	localparam int SESB_HAM_POS_MAX = 38;
	localparam int SESB_BYTES = 4;

	// Addressing and dictionary geometry
	localparam int SESB_ADDR_W = 20;
	localparam int SESB_WADDR_W = 18;
	localparam int SESB_WADDR_LSB = 2;
	localparam int SESB_SLOTS = 8;
	localparam int SESB_SLOT_W = 3;
	localparam int SESB_BIT_W = 6;
	localparam int SESB_BLK_LSB_512K = 16;
	localparam int SESB_BLK_LSB_1024K = 17;

	// Odd byte parity on the internal path
	localparam logic SESB_PAR_ODD = 1'b1;

	// Reset values
	localparam logic SESB_RST_LOW = 1'b0;
	localparam logic SESB_RST_HIGH = 1'b1;

	// Sequencer states
	typedef enum logic [1:0] {SESB_IDLE, SESB_ISSUE, SESB_TAKE, SESB_STOP} sesb_state_t;

	// Place data bits at the non power-of-two positions 1..38
	function automatic logic [SESB_HAM_POS_MAX:1] sesb_spread(input logic [SESB_DATA_W-1:0] d);
		logic [SESB_HAM_POS_MAX:1] c;
		int j;
		c = '0;
		j = 0;
		for (int p = 1; p <= SESB_HAM_POS_MAX; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p] = d[j];
				j++;
			end
		end
		return c;
	endfunction

	// Pull the data bits back out of a code vector
	function automatic logic [SESB_DATA_W-1:0] sesb_gather(input logic [SESB_HAM_POS_MAX:1] c);
		logic [SESB_DATA_W-1:0] d;
		int j;
		d = '0;
		j = 0;
		for (int p = 1; p <= SESB_HAM_POS_MAX; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[j] = c[p];
				j++;
			end
		end
		return d;
	endfunction

	// Xor of the positions of all set bits
	function automatic logic [SESB_HAM_W-1:0] sesb_syn(input logic [SESB_HAM_POS_MAX:1] c);
		logic [SESB_HAM_W-1:0] s;
		s = '0;
		for (int p = 1; p <= SESB_HAM_POS_MAX; p++) begin
			if (c[p]) begin
				s = s ^ SESB_HAM_W'(p);
			end
		end
		return s;
	endfunction

endpackage

/* sesb_encoder.sv */
// Check-code generator: 32 data bits in, 39-bit stored word out.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module sesb_encoder (
	input wire logic [sesb_pkg::SESB_DATA_W-1:0] data_in, // Data to be stored
	output logic [sesb_pkg::SESB_WORD_W-1:0] word_out // Data plus seven check bits
);
	import sesb_pkg::*;

	logic [SESB_HAM_W-1:0] ham;

	// Hamming bits cover the spread data; the top bit is overall parity
	always_comb begin
		ham = sesb_syn(sesb_spread(data_in));
		word_out = {^{ham, data_in}, ham, data_in};
	end

endmodule // sesb_encoder
`default_nettype wire

/* sesb_decoder.sv */
// Check-code decoder: corrects one bit, flags double and many multi-bit errors.
// Purely combinational so a corrected word costs no extra cycle.
`timescale 1ns/1ps
`default_nettype none
module sesb_decoder (
	input wire logic [sesb_pkg::SESB_WORD_W-1:0] word_in, // Word as read from storage
	output logic [sesb_pkg::SESB_DATA_W-1:0] data_out, // Validated or corrected data
	output logic corrected, // One bit was flipped
	output logic uncorrectable, // Double or multi-bit error
	output logic [sesb_pkg::SESB_CHK_W-1:0] syndrome // Overall bit and position
);
	import sesb_pkg::*;

	logic [SESB_HAM_POS_MAX:1] code;
	logic [SESB_HAM_W-1:0] syn;
	logic ovr;

	// Rebuild the code vector, find the failing position and flip it
	always_comb begin
		code = sesb_spread(word_in[SESB_DATA_W-1:0]);
		for (int k = 0; k < SESB_HAM_W; k++) begin
			code[2 ** k] = word_in[SESB_DATA_W + k];
		end
		syn = sesb_syn(code);
		ovr = ^word_in;
		corrected = 1'b0;
		uncorrectable = 1'b0;
		if (ovr && (syn <= SESB_HAM_W'(SESB_HAM_POS_MAX))) begin
			corrected = 1'b1;
			if (syn != '0) begin
				code[syn] = ~code[syn];
			end
		end else if (ovr || (syn != '0)) begin
			uncorrectable = 1'b1;
		end
		data_out = sesb_gather(code);
		syndrome = {ovr, syn};
	end

endmodule // sesb_decoder
`default_nettype wire

/* sesb_steer_ecc_properties.sv */
// Concurrent checks on the ports of the storage word checker.
// Assumes one clock domain and clk_en held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module sesb_steer_ecc_properties (
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire logic req_valid, // Request
	input wire logic req_ready, // Ready
	input wire logic req_write, // Store
	input wire logic [19:0] req_addr, // Byte address
	input wire logic [31:0] req_data, // Store data
	input wire logic [3:0] req_par, // Store parity
	input wire logic fetch_valid, // Fetch answer
	input wire logic [31:0] fetch_data, // Fetch data
	input wire logic [3:0] fetch_par, // Fetch parity
	input wire logic path_par_err, // Parity error
	input wire logic check_stop, // Check-stop
	input wire logic log_valid, // Error record
	input wire logic mem_en, // Storage strobe
	input wire logic mem_we, // Storage write
	input wire logic [39:0] mem_wdata // Storage data
);
	logic par_ok;
	// Odd parity of every store byte
	assign par_ok = &(req_par
		^ {^req_data[31:24], ^req_data[23:16], ^req_data[15:8], ^req_data[7:0]});
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Taken requests
	sequence s_fetch;
		req_valid && req_ready && !req_write;
	endsequence
	sequence s_store;
		req_valid && req_ready && req_write;
	endsequence
	a_store_write: assert property (s_store and par_ok |=> mem_en && mem_we
		&& mem_wdata[31:0] == $past(req_data)) else $error("store not written");
	a_store_code: assert property (mem_en && mem_we |-> ^mem_wdata[38:0] == 1'b0)
		else $error("stored word parity odd");
	a_bad_par: assert property (s_store and !par_ok |=> path_par_err && !mem_en)
		else $error("bad parity store not dropped");
	a_fetch_time: assert property (s_fetch |=> mem_en && !mem_we ##2 fetch_valid ^ check_stop)
		else $error("fetch answer late");
	a_fetch_busy: assert property (s_fetch |=> !req_ready [*2] ##1 req_ready ^ check_stop)
		else $error("ready wrong during fetch");
	a_out_par: assert property (fetch_valid |-> fetch_par ==
		~{^fetch_data[31:24], ^fetch_data[23:16], ^fetch_data[15:8], ^fetch_data[7:0]})
		else $error("fetch parity wrong");
	a_no_mchk: assert property (fetch_valid |-> !check_stop && !log_valid)
		else $error("check raised on good fetch");
	a_stop_log: assert property ($rose(check_stop) |-> log_valid)
		else $error("check-stop without record");
	a_stop_hold: assert property (check_stop |=> check_stop && !req_ready && !mem_en)
		else $error("check-stop left");
endmodule // sesb_steer_ecc_properties
bind sesb_steer_ecc sesb_steer_ecc_properties chk_u (.*);
`default_nettype wire

/* sesb_storage_model.sv */
// Behavioural storage array, 40 bits a word with spare.
// Assumes reads are strobed one cycle before the data is wanted.
`timescale 1ns/1ps
`default_nettype none
module sesb_storage_model (
	input wire logic ref_clk, // Clock
	input wire logic mem_en, // Access strobe
	input wire logic mem_we, // Write enable
	input wire logic [17:0] mem_addr, // Word address
	input wire logic [39:0] mem_wdata, // Write data
	input wire logic [39:0] flip_mask, // Read bits inverted
	output logic [39:0] mem_rdata // Read data
);
	logic [39:0] arr_q[int];
	initial mem_rdata = 40'h0;
	// Store all 40 bits, answer a read in the next cycle only
	always @(posedge ref_clk) begin
		if (mem_en && mem_we)
			arr_q[mem_addr] = mem_wdata;
		if (mem_en && !mem_we)
			mem_rdata <= arr_q[mem_addr] ^ flip_mask;
		else
			mem_rdata <= ~mem_rdata; // No stale data outside reads
	end
endmodule // sesb_storage_model
`default_nettype wire

/* sesb_steer_ecc_test.sv */
// Self-checking bench for the storage word checker with spare-bit steering.
// Assumes the storage model answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module sesb_steer_ecc_test;
	logic ref_clk = 0, reset_n = 0, clk_en = 1, iml_active = 0, size_1024k = 0;
	logic dict_we = 0, dict_en = 0, req_valid = 0, req_write = 0, in_exec = 0;
	logic [2:0] dict_slot = 0;
	logic [5:0] dict_bit = 0;
	logic [19:0] req_addr = 0, log_addr;
	logic [31:0] req_data = 0, fetch_data;
	logic [3:0] req_par = 0, fetch_par;
	logic [39:0] mem_rdata, mem_wdata, flip = 0;
	logic [17:0] mem_addr;
	logic [6:0] log_syndrome;
	logic req_ready, fetch_valid, fetch_bad, path_par_err, check_stop, log_valid, mem_en, mem_we;
	int errors = 0, tests_run = 0;
	int dbit[8];
	logic den[8];
	logic [31:0] mq[int];
	sesb_steer_ecc dut_u (.*);
	sesb_storage_model mem_u (.flip_mask(flip), .*);
	// Clock, 8 ns period
	initial forever #4 ref_clk = ~ref_clk;
	// Cut a hang short; the tests need about 2.5 us
	initial begin
		#50000;
		errors++;
		close_out;
	end
	task tick;
		@(posedge ref_clk);
		#1;
	endtask
	// Reference code word
	function automatic logic [38:0] enc(logic [31:0] d);
		logic [5:0] h;
		int j;
		h = 0;
		j = 0;
		for (int p = 3; p < 39; p++)
			if (p & (p - 1)) begin
				if (d[j])
					h ^= 6'(p);
				j++;
			end
		return {^{d, h}, h, d};
	endfunction
	// Steered bit of the word's block, -1 when none; block size follows the strap
	function automatic int sbit(logic [19:0] a);
		int b;
		b = size_1024k ? a[19:17] : a[18:16];
		return den[b] && dbit[b] < 39 ? dbit[b] : -1;
	endfunction
	function automatic logic [3:0] opar(logic [31:0] d);
		return ~{^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
	endfunction
	// Store, leaving the request up for a following access
	task store(logic [19:0] a, logic [31:0] d, logic bad);
		logic [38:0] w;
		int s;
		while (!req_ready)
			tick;
		req_valid = 1;
		req_write = 1;
		req_addr = a;
		req_data = d;
		req_par = opar(d) ^ {3'b0, bad};
		tick;
		w = enc(d);
		s = sbit(a);
		`CK(path_par_err, bad)
		if (!bad) begin
			mq[a[19:2]] = d;
			`CK(mem_addr, a[19:2])
			`CK(mem_wdata, {s < 0 ? 1'b0 : w[s], w})
		end
	endtask
	// Fetch with the given bits broken in storage
	task fetch(logic [19:0] a, logic [39:0] f, logic ex);
		logic [38:0] e;
		logic [31:0] d;
		int s;
		while (!req_ready)
			tick;
		req_valid = 1;
		req_write = 0;
		req_addr = a;
		in_exec = ex;
		flip = f;
		tick;
		req_valid = 0;
		tick;
		tick;
		e = f[38:0];
		s = sbit(a);
		if (s >= 0)
			e[s] = 0;
		d = mq[a[19:2]];
		if ($countones(e) < 2) begin
			`CK(fetch_valid, 1'b1)
			`CK(fetch_bad, 1'b0)
			`CK(fetch_data, d)
			`CK(fetch_par, opar(d))
			`CK(check_stop, 1'b0)
		end else if (ex) begin
			`CK(check_stop, 1'b1)
			`CK(log_valid, 1'b1)
			`CK(log_addr, a)
			`CK(fetch_valid, 1'b0)
		end else begin
			`CK(fetch_valid, 1'b1)
			`CK(fetch_bad, 1'b1)
		end
	endtask
	task close_out;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		logic [19:0] a;
		logic [31:0] d;
		void'($urandom(32'h369dd351));
		repeat (6) tick;
		reset_n = 1;
		tick;
		// Dictionary load, one entry per block, then a refused write
		iml_active = 1;
		dict_we = 1;
		for (int i = 0; i < 8; i++) begin
			dbit[i] = $urandom_range(44);
			den[i] = i != 3;
			dict_slot = 3'(i);
			dict_bit = 6'(dbit[i]);
			dict_en = den[i];
			tick;
		end
		iml_active = 0;
		dict_slot = 3'h0;
		dict_bit = 6'h05;
		tick;
		dict_we = 0;
		// Every single-bit position, no error, then a double error
		for (int p = 0; p < 41; p++) begin
			a = {1'b0, 17'($urandom), 2'b0};
			d = $urandom;
			store(a, d, 1'b0);
			store(a ^ 20'h4, ~d, 1'b0);
			fetch(a, p < 39 ? 40'h1 << p : p == 39 ? 40'h0 : 40'h3 << $urandom_range(37), p < 40);
		end
		// Dictionary bit plus one more in each block, steered only where the entry is enabled and below 39 (not block 3); 512K then 1024K blocks; bad parity dropped
		for (int k = 0; k < 2; k++) begin
			size_1024k = k[0];
			iml_active = 1;
			tick;
			iml_active = 0;
			for (int i = 0; i < 8; i++) begin
				a = k ? {3'(i), 15'($urandom), 2'b0} : {1'b0, 3'(i), 14'($urandom), 2'b0};
				d = $urandom;
				store(a, d, 1'b0);
				store(a, ~d, 1'b1);
				fetch(a, (40'h1 << (dbit[i] % 39)) | (40'h1 << ((dbit[i] + 7) % 39)), 1'b0);
			end
		end
		// Back to 512K blocks for the check-stop case
		size_1024k = 0;
		iml_active = 1;
		tick;
		iml_active = 0;
		// Uncorrectable during execution stops the processor
		a = 20'h30100;
		store(a, 32'h5a5a0ff0, 1'b0);
		fetch(a, 40'h30, 1'b1);
		`CK(log_syndrome, 7'h03)
		tick;
		`CK(req_ready, 1'b0)
		close_out;
	end
endmodule // sesb_steer_ecc_test
`default_nettype wire
